/* File: verilog/tisf_pkg.sv */
package tisf_pkg;
    // device register map
    localparam logic [7:0] ADDR_SRC_FIFO   = 8'h0d;
    localparam logic [7:0] ADDR_FILL_EVENT = 8'h0e;
    localparam logic [7:0] ADDR_LEVEL_THR  = 8'h0f;

    // source / fifo flags register
    localparam int SRC_CFG_HI   = 7;
    localparam int SRC_CFG_LO   = 3;
    localparam int SRC_TX_SEL   = 2;
    localparam int SRC_FULL     = 1;
    localparam int SRC_NOTEMPTY = 0;

    // fill / event flags register
    localparam int EVT_FILL_METHOD = 7;
    localparam int EVT_FILL        = 6;
    localparam int EVT_TX_DONE     = 5;
    localparam int EVT_OVERRUN     = 4;
    localparam int EVT_LEVEL_EN    = 3;
    localparam int EVT_LEVEL       = 2;
    localparam int EVT_PLL         = 1;
    localparam int EVT_LOCK_EN     = 0;

    localparam logic [4:0] SRC_CFG_RST   = 5'h00;
    localparam logic       TX_SEL_RST    = 1'b0;
    localparam logic       FILL_METH_RST = 1'b0;
    localparam logic       LEVEL_EN_RST  = 1'b0;
    localparam logic       LOCK_EN_RST   = 1'b1;
    localparam logic [7:0] LEVEL_THR_RST = 8'h00;

    // data modes
    localparam logic [1:0] MODE_CONT  = 2'h0;
    localparam logic [1:0] MODE_BUFF  = 2'h1;

    // host controller software registers
    localparam logic [2:0] HADDR_DEV_ADDR  = 3'h0;
    localparam logic [2:0] HADDR_DEV_WDATA = 3'h1;
    localparam logic [2:0] HADDR_CTRL      = 3'h2;
    localparam logic [2:0] HADDR_DEV_RDATA = 3'h3;
    localparam logic [2:0] HADDR_IRQ_STAT  = 3'h4;
    localparam logic [2:0] HADDR_IRQ_MASK  = 3'h5;
    localparam int CTRL_WRITE = 0;
    localparam int CTRL_READ  = 1;
    localparam int HEV_IRQ1_RISE = 0;
    localparam int HEV_LOCK_FALL = 1;
    localparam int HEV_READ_DONE = 2;
    localparam int HEV_WIDTH     = 3;
endpackage : tisf_pkg

/* File: verilog/tisf_if.sv */
`timescale 1ns/1ps
interface tisf_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       irq1;
    logic       lock_pin;

    modport dev (
        input  reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, irq1, lock_pin
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        input  reg_rdata, irq1, lock_pin
    );
endinterface : tisf_if

/* File: verilog/tisf_device.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module tisf_device #(
    parameter int CNT_W = 7
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    tisf_if.dev                   bus,
    input  wire logic             tx_mode_i,
    input  wire logic [1:0]       data_mode_i,
    input  wire logic             recovered_bit_clock_i,
    input  wire logic [CNT_W-1:0] fifo_count_i,
    input  wire logic [CNT_W-1:0] fifo_capacity_i,
    input  wire logic             sync_detect_i,
    input  wire logic             overrun_i,
    input  wire logic             tx_last_bit_i,
    input  wire logic             tx_start_i,
    input  wire logic [7:0]       signal_level_i,
    input  wire logic             pll_locked_i,
    output logic                  fill_active_o,
    output logic                  restart_o,
    output logic [4:0]            src_cfg_o
);
    logic [4:0] src_cfg_q;
    logic       tx_sel_q;
    logic       full_q;
    logic       notempty_q;
    logic       fill_method_q;
    logic       fill_q;
    logic       tx_done_q;
    logic       overrun_q;
    logic       level_en_q;
    logic       signal_level_flag_q;
    logic       pll_q;
    logic       lock_en_q;
    logic [7:0] signal_level_threshold_q;
    logic [7:0] rdata_q;
    logic       irq1_q;
    logic       lock_pin_q;
    logic       restart_q;

    logic wr_src;
    logic wr_evt;
    logic wr_thr;
    logic buffered;

    assign wr_src   = bus.reg_wr && (bus.reg_addr == tisf_pkg::ADDR_SRC_FIFO);
    assign wr_evt   = bus.reg_wr && (bus.reg_addr == tisf_pkg::ADDR_FILL_EVENT);
    assign wr_thr   = bus.reg_wr && (bus.reg_addr == tisf_pkg::ADDR_LEVEL_THR);
    assign buffered = (data_mode_i == tisf_pkg::MODE_BUFF);

    // plain configuration bits
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            src_cfg_q     <= tisf_pkg::SRC_CFG_RST;
            tx_sel_q      <= tisf_pkg::TX_SEL_RST;
            fill_method_q <= tisf_pkg::FILL_METH_RST;
            level_en_q    <= tisf_pkg::LEVEL_EN_RST;
            lock_en_q     <= tisf_pkg::LOCK_EN_RST;
        end else begin
            if (wr_src) begin
                src_cfg_q <= bus.reg_wdata[tisf_pkg::SRC_CFG_HI:tisf_pkg::SRC_CFG_LO];
                tx_sel_q  <= bus.reg_wdata[tisf_pkg::SRC_TX_SEL];
            end
            if (wr_evt) begin
                fill_method_q <= bus.reg_wdata[tisf_pkg::EVT_FILL_METHOD];
                level_en_q    <= bus.reg_wdata[tisf_pkg::EVT_LEVEL_EN];
                lock_en_q     <= bus.reg_wdata[tisf_pkg::EVT_LOCK_EN];
            end
        end
    end

    // threshold, same half-dB code as the level measurement
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            signal_level_threshold_q <= tisf_pkg::LEVEL_THR_RST;
        end else if (wr_thr) begin
            signal_level_threshold_q <= bus.reg_wdata;
        end
    end

    // fifo level flags
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            full_q     <= 1'b0;
            notempty_q <= 1'b0;
        end else begin
            full_q     <= (fifo_count_i == fifo_capacity_i);
            notempty_q <= (fifo_count_i != '0);
        end
    end

    // fill status: auto waits for sync, manual follows host
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fill_q <= 1'b0;
        end else if (fill_method_q) begin
            if (wr_evt) begin
                fill_q <= bus.reg_wdata[tisf_pkg::EVT_FILL];
            end
        end else if (buffered && sync_detect_i) begin
            fill_q <= 1'b1;
        end else if (wr_evt && bus.reg_wdata[tisf_pkg::EVT_FILL]) begin
            fill_q <= 1'b0;
        end
    end

    // transmit done, cleared when a new transmission starts
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tx_done_q <= 1'b0;
        end else if (tx_last_bit_i) begin
            tx_done_q <= 1'b1;
        end else if (tx_start_i || restart_q) begin
            tx_done_q <= 1'b0;
        end
    end

    // overrun flag and restart pulse
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            overrun_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_evt && bus.reg_wdata[tisf_pkg::EVT_OVERRUN];
            if (overrun_i) begin
                overrun_q <= 1'b1;
            end else if (wr_evt && bus.reg_wdata[tisf_pkg::EVT_OVERRUN]) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // signal level event
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            signal_level_flag_q <= 1'b0;
        end else if (level_en_q && (signal_level_i > signal_level_threshold_q)) begin
            signal_level_flag_q <= 1'b1;
        end else if (wr_evt && bus.reg_wdata[tisf_pkg::EVT_LEVEL]) begin
            signal_level_flag_q <= 1'b0;
        end
    end

    // pll lock flag
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pll_q <= 1'b0;
        end else if (pll_locked_i) begin
            pll_q <= 1'b1;
        end else if (wr_evt && bus.reg_wdata[tisf_pkg::EVT_PLL]) begin
            pll_q <= 1'b0;
        end
    end

    // interrupt and lock pins
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq1_q     <= 1'b0;
            lock_pin_q <= 1'b1;
        end else begin
            if (!tx_mode_i) begin
                irq1_q <= 1'b0;
            end else if (data_mode_i == tisf_pkg::MODE_CONT) begin
                irq1_q <= recovered_bit_clock_i;
            end else begin
                irq1_q <= tx_sel_q ? tx_done_q : full_q;
            end
            lock_pin_q <= lock_en_q ? pll_q : 1'b1;
        end
    end

    // read port, data valid the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (bus.reg_rd) begin
            case (bus.reg_addr)
                tisf_pkg::ADDR_SRC_FIFO: begin
                    rdata_q <= {src_cfg_q, tx_sel_q, full_q, notempty_q};
                end
                tisf_pkg::ADDR_FILL_EVENT: begin
                    rdata_q <= {fill_method_q, fill_q, tx_done_q, overrun_q,
                                level_en_q, signal_level_flag_q, pll_q, lock_en_q};
                end
                tisf_pkg::ADDR_LEVEL_THR: begin
                    rdata_q <= signal_level_threshold_q;
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign bus.reg_rdata = rdata_q;
    assign bus.irq1      = irq1_q;
    assign bus.lock_pin  = lock_pin_q;
    assign fill_active_o = fill_q;
    assign restart_o     = restart_q;
    assign src_cfg_o     = src_cfg_q;
endmodule : tisf_device

/* File: verilog/tisf_host.sv */
`timescale 1ns/1ps
module tisf_host (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    tisf_if.host            bus,
    input  wire logic [2:0] sw_addr_i,
    input  wire logic [7:0] sw_wdata_i,
    input  wire logic       sw_wr_i,
    input  wire logic       sw_rd_i,
    output logic [7:0]      sw_rdata_o,
    output logic            irq_o
);
    logic [7:0] dev_addr_q;
    logic [7:0] dev_wdata_q;
    logic       dev_wr_q;
    logic       dev_rd_q;
    logic       rd_wait_q;
    logic [7:0] dev_rdata_q;
    logic [tisf_pkg::HEV_WIDTH-1:0] stat_q;
    logic [tisf_pkg::HEV_WIDTH-1:0] mask_q;
    logic [tisf_pkg::HEV_WIDTH-1:0] ev;
    logic       irq1_prev_q;
    logic       lock_prev_q;
    logic [7:0] sw_rdata_q;
    logic       irq_q;
    logic       ctrl_wr;
    logic       stat_rd;

    assign ctrl_wr = sw_wr_i && (sw_addr_i == tisf_pkg::HADDR_CTRL);
    assign stat_rd = sw_rd_i && (sw_addr_i == tisf_pkg::HADDR_IRQ_STAT);
    assign ev[tisf_pkg::HEV_IRQ1_RISE] = bus.irq1 && !irq1_prev_q;
    assign ev[tisf_pkg::HEV_LOCK_FALL] = !bus.lock_pin && lock_prev_q;
    assign ev[tisf_pkg::HEV_READ_DONE] = rd_wait_q;

    // device access: one-cycle strobes, read data caught next cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dev_addr_q  <= 8'h00;
            dev_wdata_q <= 8'h00;
            dev_wr_q    <= 1'b0;
            dev_rd_q    <= 1'b0;
            rd_wait_q   <= 1'b0;
            dev_rdata_q <= 8'h00;
        end else begin
            if (sw_wr_i && (sw_addr_i == tisf_pkg::HADDR_DEV_ADDR)) begin
                dev_addr_q <= sw_wdata_i;
            end
            if (sw_wr_i && (sw_addr_i == tisf_pkg::HADDR_DEV_WDATA)) begin
                dev_wdata_q <= sw_wdata_i;
            end
            dev_wr_q  <= ctrl_wr && sw_wdata_i[tisf_pkg::CTRL_WRITE];
            dev_rd_q  <= ctrl_wr && sw_wdata_i[tisf_pkg::CTRL_READ]
                         && !sw_wdata_i[tisf_pkg::CTRL_WRITE];
            rd_wait_q <= dev_rd_q;
            if (rd_wait_q) begin
                dev_rdata_q <= bus.reg_rdata;
            end
        end
    end

    // sticky events, read clears, new event wins
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stat_q      <= '0;
            mask_q      <= '0;
            irq1_prev_q <= 1'b0;
            lock_prev_q <= 1'b1;
            irq_q       <= 1'b0;
        end else begin
            irq1_prev_q <= bus.irq1;
            lock_prev_q <= bus.lock_pin;
            stat_q      <= (stat_rd ? '0 : stat_q) | ev;
            if (sw_wr_i && (sw_addr_i == tisf_pkg::HADDR_IRQ_MASK)) begin
                mask_q <= sw_wdata_i[tisf_pkg::HEV_WIDTH-1:0];
            end
            irq_q <= |(((stat_rd ? '0 : stat_q) | ev) & mask_q);
        end
    end

    // software read port
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sw_rdata_q <= 8'h00;
        end else if (sw_rd_i) begin
            case (sw_addr_i)
                tisf_pkg::HADDR_DEV_ADDR:  sw_rdata_q <= dev_addr_q;
                tisf_pkg::HADDR_DEV_WDATA: sw_rdata_q <= dev_wdata_q;
                tisf_pkg::HADDR_CTRL:      sw_rdata_q <= {7'h00, rd_wait_q | dev_rd_q};
                tisf_pkg::HADDR_DEV_RDATA: sw_rdata_q <= dev_rdata_q;
                tisf_pkg::HADDR_IRQ_STAT:  sw_rdata_q <= {5'h00, stat_q};
                tisf_pkg::HADDR_IRQ_MASK:  sw_rdata_q <= {5'h00, mask_q};
                default:                   sw_rdata_q <= 8'h00;
            endcase
        end else begin
            sw_rdata_q <= 8'h00;
        end
    end

    assign bus.reg_addr  = dev_addr_q;
    assign bus.reg_wdata = dev_wdata_q;
    assign bus.reg_wr    = dev_wr_q;
    assign bus.reg_rd    = dev_rd_q;
    assign sw_rdata_o    = sw_rdata_q;
    assign irq_o         = irq_q;
endmodule : tisf_host

/* File: tb/tisf_chk.sv */
`timescale 1ns/1ps
module tisf_chk (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq1,
    input wire logic       lock_pin
);
    logic [7:0] thr_q;
    logic [5:0] src_q;
    logic [2:0] cfg_q;
    logic       rd_evt, rd_src, rd_thr;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // shadow of the writable fields
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            thr_q <= tisf_pkg::LEVEL_THR_RST;
            src_q <= 6'h00;
            cfg_q <= 3'h1;
        end else if (reg_wr && reg_addr == tisf_pkg::ADDR_LEVEL_THR) begin
            thr_q <= reg_wdata;
        end else if (reg_wr && reg_addr == tisf_pkg::ADDR_SRC_FIFO) begin
            src_q <= reg_wdata[7:2];
        end else if (reg_wr && reg_addr == tisf_pkg::ADDR_FILL_EVENT) begin
            cfg_q <= {reg_wdata[7], reg_wdata[3], reg_wdata[0]};
        end
    end
    assign rd_evt = reg_rd && reg_addr == tisf_pkg::ADDR_FILL_EVENT;
    assign rd_src = reg_rd && reg_addr == tisf_pkg::ADDR_SRC_FIFO;
    assign rd_thr = reg_rd && reg_addr == tisf_pkg::ADDR_LEVEL_THR;
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property ($past(reg_rd) && !$past(rd_evt || rd_src || rd_thr)
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_thr_read: assert property ($past(rd_thr) |-> reg_rdata == $past(thr_q))
        else $error("threshold readback wrong");
    a_evt_cfg: assert property ($past(rd_evt)
        |-> {reg_rdata[7], reg_rdata[3], reg_rdata[0]} == $past(cfg_q))
        else $error("fill method or enable bits wrong");
    a_src_cfg: assert property ($past(rd_src) |-> reg_rdata[7:2] == $past(src_q))
        else $error("source select bits wrong");
    a_full_nonempty: assert property ($past(rd_src) && reg_rdata[1] |-> reg_rdata[0])
        else $error("full without data present");
    a_lock_follow: assert property ($past(rd_evt)
        |-> lock_pin == (reg_rdata[0] ? reg_rdata[1] : 1'b1))
        else $error("lock pin does not follow flag");
    a_lock_held: assert property (!cfg_q[0] && !$past(cfg_q[0]) |-> lock_pin)
        else $error("lock pin low with detection off");
endmodule : tisf_chk

/* File: tb/test_transceiver_irq_status_flags.sv */
`timescale 1ns/1ps
module test_transceiver_irq_status_flags;
    logic       mclk_i, rst_i, txm, rbc, pll, sw_wr, sw_rd, irq, fill, rstr;
    logic [3:0] pul;
    logic [1:0] dmode;
    logic [6:0] cnt, cap;
    logic [7:0] lvl, sw_wd, sw_rdat, d;
    logic [2:0] sw_a;
    logic [4:0] scfg;
    int         n_fail, samples_checked, n_rstr;
    tisf_if i_tisf_if ();
    tisf_device i_tisf_device (.mclk_i(mclk_i), .rst_i(rst_i), .bus(i_tisf_if),
        .tx_mode_i(txm), .data_mode_i(dmode), .recovered_bit_clock_i(rbc),
        .fifo_count_i(cnt), .fifo_capacity_i(cap), .sync_detect_i(pul[0]),
        .overrun_i(pul[1]), .tx_last_bit_i(pul[2]), .tx_start_i(pul[3]),
        .signal_level_i(lvl), .pll_locked_i(pll), .fill_active_o(fill),
        .restart_o(rstr), .src_cfg_o(scfg));
    tisf_host i_tisf_host (.mclk_i(mclk_i), .rst_i(rst_i), .bus(i_tisf_if), .sw_addr_i(sw_a),
        .sw_wdata_i(sw_wd), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdat), .irq_o(irq));
    tisf_chk i_tisf_chk (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr(i_tisf_if.reg_addr),
        .reg_wdata(i_tisf_if.reg_wdata), .reg_wr(i_tisf_if.reg_wr), .reg_rd(i_tisf_if.reg_rd),
        .reg_rdata(i_tisf_if.reg_rdata), .irq1(i_tisf_if.irq1), .lock_pin(i_tisf_if.lock_pin));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic sw_w(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        sw_a  <= a;
        sw_wd <= v;
        sw_wr <= 1'b1;
        @(posedge mclk_i);
        sw_wr <= 1'b0;
    endtask : sw_w
    task automatic sw_r(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        sw_a  <= a;
        sw_rd <= 1'b1;
        @(posedge mclk_i);
        sw_rd <= 1'b0;
        #1;
        v = sw_rdat;
    endtask : sw_r
    task automatic dw(input logic [7:0] a, input logic [7:0] v);
        sw_w(tisf_pkg::HADDR_DEV_ADDR, a);
        sw_w(tisf_pkg::HADDR_DEV_WDATA, v);
        sw_w(tisf_pkg::HADDR_CTRL, 8'h01);
        tick(2);
    endtask : dw
    task automatic ck_reg(input logic [7:0] a, input logic [7:0] e);
        sw_w(tisf_pkg::HADDR_DEV_ADDR, a);
        sw_w(tisf_pkg::HADDR_CTRL, 8'h02);
        tick(3);
        sw_r(tisf_pkg::HADDR_DEV_RDATA, d);
        chk(d, e);
    endtask : ck_reg
    task automatic pulse(input int i);
        @(posedge mclk_i) pul[i] <= 1'b1;
        @(posedge mclk_i) pul[i] <= 1'b0;
        tick(2);
    endtask : pulse
    task automatic t_level;
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h01);
        ck_reg(8'h10, 8'h00);
        dw(tisf_pkg::ADDR_LEVEL_THR, 8'h40);
        ck_reg(tisf_pkg::ADDR_LEVEL_THR, 8'h40);
        @(posedge mclk_i) lvl <= 8'h41;
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h01);
        @(posedge mclk_i) lvl <= 8'h40;
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h09);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h09);
        @(posedge mclk_i) lvl <= 8'h41;
        @(posedge mclk_i) lvl <= 8'h00;
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h0d);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h0d);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h09);
    endtask : t_level
    task automatic t_irq;
        @(posedge mclk_i) cnt <= 7'h08;
        ck_reg(tisf_pkg::ADDR_SRC_FIFO, 8'h03);
        @(posedge mclk_i) cnt <= 7'h03;
        ck_reg(tisf_pkg::ADDR_SRC_FIFO, 8'h01);
        sw_w(tisf_pkg::HADDR_IRQ_MASK, 8'h01);
        @(posedge mclk_i) txm <= 1'b1;
        @(posedge mclk_i) rbc <= 1'b1;
        tick(3);
        chk(8'(i_tisf_if.irq1), 8'h01);
        chk(8'(irq), 8'h01);
        @(posedge mclk_i) rbc <= 1'b0;
        tick(2);
        chk(8'(i_tisf_if.irq1), 8'h00);
        sw_r(tisf_pkg::HADDR_IRQ_STAT, d);
        chk(d & 8'h01, 8'h01);
        tick(1);
        chk(8'(irq), 8'h00);
        sw_w(tisf_pkg::HADDR_IRQ_MASK, 8'h00);
        @(posedge mclk_i) rbc <= 1'b1;
        tick(3);
        chk(8'(irq), 8'h00);
        @(posedge mclk_i) dmode <= tisf_pkg::MODE_BUFF;
        @(posedge mclk_i) cnt <= 7'h08;
        tick(2);
        chk(8'(i_tisf_if.irq1), 8'h01);
        @(posedge mclk_i) cnt <= 7'h00;
        tick(2);
        chk(8'(i_tisf_if.irq1), 8'h00);
        dw(tisf_pkg::ADDR_SRC_FIFO, 8'hfc);
        ck_reg(tisf_pkg::ADDR_SRC_FIFO, 8'hfc);
        chk(8'(scfg), 8'h1f);
        pulse(2);
        chk(8'(i_tisf_if.irq1), 8'h01);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h29);
        pulse(3);
        chk(8'(i_tisf_if.irq1), 8'h00);
        dw(tisf_pkg::ADDR_SRC_FIFO, 8'h00);
        @(posedge mclk_i) dmode <= 2'h2;
        @(posedge mclk_i) cnt <= 7'h08;
        tick(2);
        chk(8'(i_tisf_if.irq1), 8'h01);
        @(posedge mclk_i) txm <= 1'b0;
        @(posedge mclk_i) cnt <= 7'h00;
    endtask : t_irq
    task automatic t_fill;
        @(posedge mclk_i) dmode <= tisf_pkg::MODE_BUFF;
        pulse(0);
        chk(8'(fill), 8'h01);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h49);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h49);
        chk(8'(fill), 8'h00);
        pulse(0);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h49);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'hc9);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h89);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'hc9);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'hc9);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h89);
        pulse(0);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h89);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h09);
    endtask : t_fill
    task automatic t_ovr_pll;
        int b;
        pulse(1);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h19);
        b = n_rstr;
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h19);
        chk(8'(n_rstr - b), 8'h01);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h09);
        pulse(1);
        sw_w(tisf_pkg::HADDR_DEV_WDATA, 8'h19);
        sw_w(tisf_pkg::HADDR_CTRL, 8'h01);
        // overrun lands on the clearing write
        pul[1] <= 1'b1;
        @(posedge mclk_i) pul[1] <= 1'b0;
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h19);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h19);
        @(posedge mclk_i) pll <= 1'b1;
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h0b);
        chk(8'(i_tisf_if.lock_pin), 8'h01);
        @(posedge mclk_i) pll <= 1'b0;
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h0b);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h0b);
        ck_reg(tisf_pkg::ADDR_FILL_EVENT, 8'h09);
        chk(8'(i_tisf_if.lock_pin), 8'h00);
        sw_r(tisf_pkg::HADDR_IRQ_STAT, d);
        chk(d & 8'h06, 8'h06);
        dw(tisf_pkg::ADDR_FILL_EVENT, 8'h08);
        tick(1);
        chk(8'(i_tisf_if.lock_pin), 8'h01);
    endtask : t_ovr_pll
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // count restart pulses, one per clearing write
    always @(posedge mclk_i) begin
        if (rst_i) begin
            n_rstr <= 0;
        end else if (rstr === 1'b1) begin
            n_rstr <= n_rstr + 1;
        end
    end
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
    initial begin
        {rst_i, txm, rbc, pll, sw_wr, sw_rd} = 6'h20;
        {pul, dmode, cnt, lvl, sw_a, sw_wd} = '0;
        cap = 7'h08;
        n_fail = 0;
        samples_checked = 0;
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_level();
        t_irq();
        t_fill();
        t_ovr_pll();
        wrap_up();
    end
endmodule : test_transceiver_irq_status_flags
